// ### serial_rx_status_vector_test.sv
// Testbench of the receive status and vector readback block
`timescale 1ns/1ps
module serial_rx_status_vector_test;
  typedef struct packed {
    logic [1:0] len;
    logic [3:0] rem;
    logic [2:0] res;
  } srsv_row_t;

  logic                clock;
  logic                sys_rst;
  logic                psel, penable, pwrite, pready, pslverr;
  logic [7:0]          paddr;
  logic [31:0]         pwdata, prdata, rd_v;
  srsv_pkg::srsv_rx_t  rx_in;
  logic                tx_idle, frame_stretch, irq, err_v;
  int                  n_errors, total_checks, n_hi;
  srsv_row_t           rows [11];

  srsv_top #(.CLK_PER_BIT(16)) i_dut (
    .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .rx_in(rx_in), .tx_idle(tx_idle), .frame_stretch(frame_stretch), .irq(irq)
  );
  srsv_host i_host (
    .clock(clock), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr)
  );

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end
  always @(posedge clock) if (frame_stretch === 1'b1) n_hi <= n_hi + 1;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    i_host.xfer(1'b1, a, d, rd_v, err_v);
  endtask
  task automatic rd(input logic [7:0] a);
    i_host.xfer(1'b0, a, 32'h0, rd_v, err_v);
  endtask
  task automatic push(input logic [7:0] d, input logic p, fe, ce, ef, input logic [3:0] m);
    @(posedge clock);
    rx_in <= {1'b1, d, p, fe, ce, ef, m};
    @(posedge clock);
    rx_in <= ~{1'b1, d, p, fe, ce, ef, m};
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    #300000;
    n_errors++;
    $display("watchdog expired");
    complete_run();
  end

  initial begin
    sys_rst = 1'b1;
    rx_in = '0;
    tx_idle = 1'b1;
    n_errors = 0;
    total_checks = 0;
    n_hi = 0;
    rows = '{'{2'h3, 4'h3, 3'h4}, '{2'h3, 4'h4, 3'h2}, '{2'h3, 4'h5, 3'h6},
             '{2'h3, 4'h6, 3'h1}, '{2'h3, 4'h7, 3'h5}, '{2'h3, 4'h1, 3'h7},
             '{2'h3, 4'h2, 3'h0}, '{2'h3, 4'h0, srsv_pkg::RES_NONE_8},
             '{2'h1, 4'h0, srsv_pkg::RES_NONE_7}, '{2'h2, 4'h0, srsv_pkg::RES_NONE_6},
             '{2'h0, 4'h0, srsv_pkg::RES_NONE_5}};
    repeat (8) @(posedge clock);
    sys_rst <= 1'b0;
    rd(srsv_pkg::OFF_STATUS);
    chk("status after reset", {28'h0, srsv_pkg::RES_NONE_8, 1'b1}, rd_v);
    rd(srsv_pkg::OFF_VECRD);
    chk("vector on first channel", 32'h1, {31'h0, err_v});
    rd(8'h24);
    chk("unmapped refusal", 32'h1, {31'h0, err_v});
    rd(srsv_pkg::OFF_IRQ_STAT);
    chk("event status after reset", 32'h0, rd_v);
    $display("test reset done");
    wr(srsv_pkg::OFF_IRQ_EN, 32'hF);
    tx_idle <= 1'b0;
    repeat (4) @(posedge clock);
    rd(srsv_pkg::OFF_STATUS);
    chk("all sent busy", 32'h0, {31'h0, rd_v[0]});
    chk("no all sent irq", 32'h0, {31'h0, irq});
    wr(srsv_pkg::OFF_CTRL, 32'h1);
    rd(srsv_pkg::OFF_STATUS);
    chk("all sent sync", 32'h1, {31'h0, rd_v[0]});
    tx_idle <= 1'b1;
    $display("test all sent done");
    foreach (rows[i]) begin
      wr(srsv_pkg::OFF_CTRL, {24'h0, 1'b1, rows[i].len, 5'h2});
      push(8'(8'h40 + i), 1'b0, 1'b0, 1'b0, 1'b1, rows[i].rem);
      rd(srsv_pkg::OFF_STATUS);
      chk("residue and end", {28'h8, rows[i].res}, {25'h0, rd_v[7:1]});
      rd(srsv_pkg::OFF_DATA);
      chk("frame data", 32'(8'h40 + i), rd_v);
    end
    push(8'h55, 1'b0, 1'b0, 1'b1, 1'b0, 4'h0);
    rd(srsv_pkg::OFF_STATUS);
    chk("crc set end cleared", 32'h1, {30'h0, rd_v[7:6]});
    rd(srsv_pkg::OFF_DATA);
    push(8'h56, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
    rd(srsv_pkg::OFF_STATUS);
    chk("crc follows char", 32'h0, {31'h0, rd_v[6]});
    rd(srsv_pkg::OFF_DATA);
    $display("test frames done");
    wr(srsv_pkg::OFF_IRQ_CLR, 32'hF);
    wr(srsv_pkg::OFF_CTRL, 32'h84);
    push(8'h01, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
    push(8'h03, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
    rd(srsv_pkg::OFF_STATUS);
    chk("parity head", 32'h1, {31'h0, rd_v[4]});
    rd(srsv_pkg::OFF_DATA);
    chk("parity data", 32'h1, rd_v);
    rd(srsv_pkg::OFF_STATUS);
    chk("parity latched", 32'h1, {31'h0, rd_v[4]});
    rd(srsv_pkg::OFF_IRQ_STAT);
    chk("parity event", 32'h1, {31'h0, rd_v[1]});
    wr(srsv_pkg::OFF_IRQ_EN, 32'h0);
    repeat (3) @(posedge clock);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(srsv_pkg::OFF_IRQ_EN, 32'hF);
    repeat (3) @(posedge clock);
    chk("irq enabled", 32'h1, {31'h0, irq});
    wr(srsv_pkg::OFF_CMD, {29'h0, srsv_pkg::CMD_ERR_RESET});
    rd(srsv_pkg::OFF_STATUS);
    chk("parity reset", 32'h0, {31'h0, rd_v[4]});
    rd(srsv_pkg::OFF_DATA);
    wr(srsv_pkg::OFF_IRQ_CLR, 32'hF);
    repeat (3) @(posedge clock);
    chk("irq cleared", 32'h0, {31'h0, irq});
    wr(srsv_pkg::OFF_CTRL, 32'h8C);
    push(8'h03, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
    rd(srsv_pkg::OFF_STATUS);
    chk("odd parity", 32'h1, {31'h0, rd_v[4]});
    rd(srsv_pkg::OFF_DATA);
    wr(srsv_pkg::OFF_CMD, {29'h0, srsv_pkg::CMD_ERR_RESET});
    $display("test parity done");
    wr(srsv_pkg::OFF_CTRL, 32'h90);
    wr(srsv_pkg::OFF_VECWR, 32'hA5);
    for (int k = 0; k < 4; k++) push(8'(8'h11 + k), 1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
    rd(srsv_pkg::OFF_IRQ_STAT);
    chk("overrun event", 32'h1, {31'h0, rd_v[0]});
    rd(srsv_pkg::OFF_DATA);
    chk("first char", 32'h11, rd_v);
    rd(srsv_pkg::OFF_STATUS);
    chk("clean char", 32'h0, {31'h0, rd_v[5]});
    rd(srsv_pkg::OFF_DATA);
    rd(srsv_pkg::OFF_STATUS);
    chk("overrun flag", 32'h1, {31'h0, rd_v[5]});
    rd(srsv_pkg::OFF_VECRD);
    chk("special vector", {24'h0, 4'hA, srsv_pkg::VEC_SPECIAL, 1'b1}, rd_v);
    rd(srsv_pkg::OFF_DATA);
    chk("overwritten char", 32'h14, rd_v);
    rd(srsv_pkg::OFF_STATUS);
    chk("overrun latched", 32'h1, {31'h0, rd_v[5]});
    wr(srsv_pkg::OFF_CMD, {29'h0, srsv_pkg::CMD_ERR_RESET});
    wr(srsv_pkg::OFF_IRQ_CLR, 32'hF);
    rd(srsv_pkg::OFF_STATUS);
    chk("overrun reset", 32'h0, {31'h0, rd_v[5]});
    rd(srsv_pkg::OFF_VECRD);
    chk("idle vector", {24'h0, 4'hA, srsv_pkg::VEC_NONE, 1'b1}, rd_v);
    wr(srsv_pkg::OFF_CTRL, 32'h80);
    rd(srsv_pkg::OFF_VECRD);
    chk("raw vector", 32'hA5, rd_v);
    $display("test overrun done");
    n_hi = 0;
    push(8'h21, 1'b0, 1'b1, 1'b0, 1'b0, 4'h0);
    repeat (20) @(posedge clock);
    chk("stretch cycles", 32'h8, 32'(n_hi));
    rd(srsv_pkg::OFF_STATUS);
    chk("framing flag", 32'h1, {31'h0, rd_v[6]});
    rd(srsv_pkg::OFF_DATA);
    push(8'h22, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
    rd(srsv_pkg::OFF_STATUS);
    chk("framing not latched", 32'h0, {31'h0, rd_v[6]});
    rd(srsv_pkg::OFF_DATA);
    $display("test framing done");
    complete_run();
  end
endmodule // serial_rx_status_vector_test

// ### srsv_chk.sv
// Checker of bus answer timing, interrupt causes and framing stretch
`timescale 1ns/1ps
module srsv_chk #(
  parameter int CLK_PER_BIT = 16
) (
  input wire logic                clock,
  input wire logic                sys_rst,
  input wire logic                psel,
  input wire logic                penable,
  input wire logic                pwrite,
  input wire logic [7:0]          paddr,
  input wire logic [31:0]         pwdata,
  input wire logic [31:0]         prdata,
  input wire logic                pready,
  input wire logic                pslverr,
  input wire srsv_pkg::srsv_rx_t  rx_in,
  input wire logic                tx_idle,
  input wire logic                frame_stretch,
  input wire logic                irq
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  wire acc_wr   = psel && penable && pwrite;
  wire bad_char = rx_in.valid && rx_in.frame_err;

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_stretch_run;
    frame_stretch [*8] ##1 !frame_stretch;
  endsequence

  a_ready_after_setup: assert property (s_setup |=> pready && penable)
    else $error("no answer one cycle after setup");
  a_ready_single: assert property (pready |=> !pready)
    else $error("answer held longer than one cycle");
  a_no_stray_ready: assert property (!psel |=> !pready)
    else $error("answer without a request");
  a_err_zero_data: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("refused access returned data");
  a_irq_has_cause: assert property ($rose(irq) |-> $past(rx_in.valid, 2)
    || $past(psel && penable, 2))
    else $error("interrupt rose without an event");
  a_irq_drop_cause: assert property ($fell(irq) |-> $past(acc_wr, 2))
    else $error("interrupt fell without a write");
  a_stretch_len: assert property ($rose(frame_stretch) |-> s_stretch_run)
    else $error("stretch length wrong");
  a_stretch_cause: assert property ($rose(frame_stretch) |-> $past(bad_char, 1)
    || $past(bad_char, 2))
    else $error("stretch without framing error");
endmodule // srsv_chk

bind srsv_top srsv_chk #(.CLK_PER_BIT(CLK_PER_BIT)) i_chk (
  .clock(clock), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rx_in(rx_in), .tx_idle(tx_idle), .frame_stretch(frame_stretch), .irq(irq)
);

// ### srsv_host.sv
// Host processor model: APB master with one transfer task
`timescale 1ns/1ps
module srsv_host (
  input wire logic         clock,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input wire logic [31:0]  prdata,
  input wire logic         pready,
  input wire logic         pslverr
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end

  // Released lines show the inverse so stale values cannot pass
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask
endmodule // srsv_host

// ### srsv_pkg.sv
// Package: register map, field layout and shared types of the receive status block
package srsv_pkg;

  // APB register byte offsets
  localparam logic [7:0] OFF_STATUS   = 8'h00;  // receive_special_status (RO)
  localparam logic [7:0] OFF_VECRD    = 8'h04;  // interrupt_vector_readback (RO)
  localparam logic [7:0] OFF_VECWR    = 8'h08;  // vector_write_register (RW)
  localparam logic [7:0] OFF_CTRL     = 8'h0C;  // mode / parity / vectoring control (RW)
  localparam logic [7:0] OFF_CMD      = 8'h10;  // command_write_register (WO)
  localparam logic [7:0] OFF_DATA     = 8'h14;  // receive data, read pops head (RO)
  localparam logic [7:0] OFF_IRQ_STAT = 8'h18;  // sticky event status (RO)
  localparam logic [7:0] OFF_IRQ_EN   = 8'h1C;  // event enable (RW)
  localparam logic [7:0] OFF_IRQ_CLR  = 8'h20;  // event clear, write one (WO)

  // Status byte field positions
  localparam int BIT_ALL_SENT = 0;
  localparam int BIT_RES_LO   = 1;
  localparam int BIT_PAR      = 4;
  localparam int BIT_OVR      = 5;
  localparam int BIT_CRCF     = 6;
  localparam int BIT_EOF      = 7;

  // Control register field positions
  localparam int CTL_MODE_LO  = 0;   // two bits of mode
  localparam int CTL_PAR_EN   = 2;
  localparam int CTL_PAR_ODD  = 3;
  localparam int CTL_SAV      = 4;   // status-modified vectoring
  localparam int CTL_LEN_LO   = 5;   // two bits of character length
  localparam int CTL_IS_CHB   = 7;   // instance is the second channel

  // Command codes
  localparam logic [2:0] CMD_ERR_RESET = 3'h6;

  // Reset values
  localparam logic [7:0] RST_VECWR = 8'h00;
  localparam logic [7:0] RST_CTRL  = 8'h00;
  localparam logic [3:0] RST_IRQ   = 4'h0;

  // Receive queue depth (overrun beyond this)
  localparam int RX_DEPTH = 3;

  // Vector bits three..one for nothing pending, for receive available and for special receive
  localparam logic [2:0] VEC_NONE    = 3'h3;  // V3=0 V2=1 V1=1
  localparam logic [2:0] VEC_SPECIAL = 3'h7;
  localparam logic [2:0] VEC_RXAVAIL = 3'h6;

  // Residue codes for no residue per character length
  localparam logic [2:0] RES_NONE_8 = 3'h3;
  localparam logic [2:0] RES_NONE_7 = 3'h0;
  localparam logic [2:0] RES_NONE_6 = 3'h2;
  localparam logic [2:0] RES_NONE_5 = 3'h1;

  typedef enum logic [1:0] {
    SRSV_MODE_ASYNC = 2'h0,
    SRSV_MODE_SYNC  = 2'h1,
    SRSV_MODE_SDLC  = 2'h2
  } srsv_mode_t;

  typedef enum logic [1:0] {
    SRSV_LEN_5 = 2'h0,
    SRSV_LEN_7 = 2'h1,
    SRSV_LEN_6 = 2'h2,
    SRSV_LEN_8 = 2'h3
  } srsv_len_t;

  // One received character with its own status
  typedef struct packed {
    logic [7:0] data;
    logic       par_err;
    logic       ovr;
    logic       crcf;
    logic       eof;
    logic [2:0] residue;
  } srsv_char_t;

  // Receiver event input group
  typedef struct packed {
    logic       valid;
    logic [7:0] data;
    logic       par_bit;
    logic       frame_err;
    logic       crc_err;
    logic       end_flag;
    logic [3:0] rem_bits;   // I-field bits left over in last chars, 0 = none
  } srsv_rx_t;

endpackage

// ### srsv_rx_queue.sv
// Receive character queue with overwrite-on-overrun of the newest entry
`timescale 1ns/1ps
module srsv_rx_queue #(
  parameter int DEPTH = 3
) (
  input  wire logic               clock,
  input  wire logic               sys_rst,
  input  wire logic               push,
  input  wire srsv_pkg::srsv_char_t push_char,
  input  wire logic               pop,
  output srsv_pkg::srsv_char_t    head,
  output logic                    not_empty,
  output logic                    overrun
);

  srsv_pkg::srsv_char_t mem_r [DEPTH];
  logic [1:0] rd_r;
  logic [1:0] wr_r;
  logic [2:0] cnt_r;
  logic       full;
  logic       do_pop;

  assign full      = (cnt_r == 3'(DEPTH));
  assign do_pop    = pop && (cnt_r != 3'h0);
  assign head      = mem_r[rd_r];
  assign not_empty = (cnt_r != 3'h0);
  assign overrun   = push && full && !do_pop;

  function automatic logic [1:0] inc(input logic [1:0] p);
    inc = (p == 2'(DEPTH - 1)) ? 2'h0 : p + 2'h1;
  endfunction

  // Overrun overwrites the newest slot and marks it
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_r  <= 2'h0;
      wr_r  <= 2'h0;
      cnt_r <= 3'h0;
    end else begin
      if (push && overrun) begin
        mem_r[(wr_r == 2'h0) ? 2'(DEPTH - 1) : wr_r - 2'h1] <=
          '{data: push_char.data, par_err: push_char.par_err, ovr: 1'b1,
            crcf: push_char.crcf, eof: push_char.eof, residue: push_char.residue};
      end else if (push) begin
        mem_r[wr_r] <= push_char;
        wr_r        <= inc(wr_r);
      end
      if (do_pop) begin
        rd_r <= inc(rd_r);
      end
      if (push && !overrun && !do_pop) begin
        cnt_r <= cnt_r + 3'h1;
      end else if (do_pop && !push) begin
        cnt_r <= cnt_r - 3'h1;
      end
    end
  end

endmodule // srsv_rx_queue

// ### srsv_top.sv
// Receive special status and vector readback for one serial channel, APB slave
//
// Function
// - All-sent when transmitter drained; sync always set
// - Residue bits give I-field length at frame end
// - Eight-bit residue code table, bits right-justified
// - No-residue codes per character length
// - Parity error latched until error reset
// - Overrun flags overwritten char, then latches
// - Overrun char interrupts with special receive vector
// - Async framing error per char, half-bit extension
// - Sync/framed CRC bit follows each character
// - End-of-frame on closing flag, cleared or updated
// - Vector readback raw or status-modified
// - Vector shows highest pending; none gives 011
// - Vector readback exists only on second channel
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
module srsv_top #(
  parameter int CLK_PER_BIT = 16
) (
  input  wire logic             clock,
  input  wire logic             sys_rst,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic [31:0]           prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire srsv_pkg::srsv_rx_t rx_in,
  input  wire logic             tx_idle,
  output logic                  frame_stretch,
  output logic                  irq
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers and decode

  logic [7:0]  vecwr_r;
  logic [7:0]  ctrl_r;
  logic [3:0]  irq_stat_r;
  logic [3:0]  irq_en_r;
  logic        par_lat_r;
  logic        ovr_lat_r;
  logic        crcf_r;
  logic        eof_r;
  logic        all_sent_r;
  logic        tx_idle_s1_r;
  logic        tx_idle_s2_r;
  logic [7:0]  stretch_cnt_r;
  logic        stretch_r;
  logic        irq_r;
  logic [31:0] prdata_r;
  logic        pready_r;
  logic        pslverr_r;

  srsv_pkg::srsv_mode_t mode;
  srsv_pkg::srsv_len_t  clen;
  srsv_pkg::srsv_char_t new_char;
  srsv_pkg::srsv_char_t head;
  logic        is_chb;
  logic        acc;
  logic        wr_acc;
  logic        rd_acc;
  logic        err_reset;
  logic        pop;
  logic        not_empty;
  logic        overrun;
  logic        par_bad;
  logic [7:0]  status_byte;
  logic [7:0]  vec_byte;
  logic [3:0]  evt;
  logic        hit;
  logic        sav;

  assign mode   = srsv_pkg::srsv_mode_t'(ctrl_r[srsv_pkg::CTL_MODE_LO +: 2]);
  assign clen   = srsv_pkg::srsv_len_t'(ctrl_r[srsv_pkg::CTL_LEN_LO +: 2]);
  assign is_chb = ctrl_r[srsv_pkg::CTL_IS_CHB];
  assign sav    = ctrl_r[srsv_pkg::CTL_SAV];

  // Zero-wait APB: answer registered one cycle after setup
  assign acc    = psel && penable && pready_r;
  assign wr_acc = acc && pwrite;
  assign rd_acc = acc && !pwrite;

  function automatic logic addr_ok(input logic [7:0] a, input logic chb);
    case (a)
      srsv_pkg::OFF_STATUS, srsv_pkg::OFF_VECWR, srsv_pkg::OFF_CTRL,
      srsv_pkg::OFF_CMD, srsv_pkg::OFF_DATA, srsv_pkg::OFF_IRQ_STAT,
      srsv_pkg::OFF_IRQ_EN, srsv_pkg::OFF_IRQ_CLR: addr_ok = 1'b1;
      srsv_pkg::OFF_VECRD: addr_ok = chb;
      default: addr_ok = 1'b0;
    endcase
  endfunction

  assign err_reset = wr_acc && (paddr == srsv_pkg::OFF_CMD)
                     && (pwdata[2:0] == srsv_pkg::CMD_ERR_RESET);
  assign pop       = rd_acc && (paddr == srsv_pkg::OFF_DATA);

  ////////////////////////////////////////////////////////////////////////////
  // Character status capture

  // Residue code from left-over I-field bits
  function automatic logic [2:0] residue_code(input logic [3:0] rem,
                                              input srsv_pkg::srsv_len_t l);
    logic [2:0] r;
    r = srsv_pkg::RES_NONE_8;
    if (rem == 4'h0) begin
      case (l)
        srsv_pkg::SRSV_LEN_8: r = srsv_pkg::RES_NONE_8;
        srsv_pkg::SRSV_LEN_7: r = srsv_pkg::RES_NONE_7;
        srsv_pkg::SRSV_LEN_6: r = srsv_pkg::RES_NONE_6;
        default:              r = srsv_pkg::RES_NONE_5;
      endcase
    end else begin
      // Eight-bit table, bit order (2,1,0), right-justified bits
      case (rem)
        4'h3:    r = 3'h4;
        4'h4:    r = 3'h2;
        4'h5:    r = 3'h6;
        4'h6:    r = 3'h1;
        4'h7:    r = 3'h5;
        4'h1:    r = 3'h7;
        4'h2:    r = 3'h0;
        default: r = 3'h3;
      endcase
    end
    residue_code = r;
  endfunction

  assign par_bad = ctrl_r[srsv_pkg::CTL_PAR_EN]
                   && ((^rx_in.data ^ rx_in.par_bit) != ctrl_r[srsv_pkg::CTL_PAR_ODD]);

  always_comb begin
    new_char         = '0;
    new_char.data    = rx_in.data;
    new_char.par_err = par_bad;
    new_char.crcf    = (mode == srsv_pkg::SRSV_MODE_ASYNC)
                       ? rx_in.frame_err : rx_in.crc_err;
    new_char.eof     = (mode == srsv_pkg::SRSV_MODE_SDLC) && rx_in.end_flag;
    new_char.residue = (mode == srsv_pkg::SRSV_MODE_SDLC) && rx_in.end_flag
                       ? residue_code(rx_in.rem_bits, clen)
                       : srsv_pkg::RES_NONE_8;
  end

  srsv_rx_queue #(
    .DEPTH (srsv_pkg::RX_DEPTH)
  ) u_queue (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .push      (rx_in.valid),
    .push_char (new_char),
    .pop       (pop),
    .head      (head),
    .not_empty (not_empty),
    .overrun   (overrun)
  );

  // Latched error bits; set wins over error reset
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      par_lat_r <= 1'b0;
      ovr_lat_r <= 1'b0;
    end else begin
      if (pop && not_empty && head.par_err) begin
        par_lat_r <= 1'b1;
      end else if (err_reset) begin
        par_lat_r <= 1'b0;
      end
      if (pop && not_empty && head.ovr) begin
        ovr_lat_r <= 1'b1;
      end else if (err_reset) begin
        ovr_lat_r <= 1'b0;
      end
    end
  end

  // Unlatched CRC/framing and end-of-frame, follow each head character
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      crcf_r <= 1'b0;
      eof_r  <= 1'b0;
    end else if (pop && not_empty) begin
      crcf_r <= head.crcf;
      eof_r  <= head.eof;
    end else if (err_reset) begin
      crcf_r <= 1'b0;
      eof_r  <= 1'b0;
    end
  end

  // Framing error stretches the character by half a bit
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      stretch_cnt_r <= 8'h00;
      stretch_r     <= 1'b0;
    end else if (rx_in.valid && rx_in.frame_err
                 && (mode == srsv_pkg::SRSV_MODE_ASYNC)) begin
      stretch_cnt_r <= 8'(CLK_PER_BIT / 2);
      stretch_r     <= 1'b1;
    end else if (stretch_cnt_r > 8'h01) begin
      stretch_cnt_r <= stretch_cnt_r - 8'h01;
    end else begin
      stretch_cnt_r <= 8'h00;
      stretch_r     <= 1'b0;
    end
  end

  // All-sent: synchronised transmitter idle in async, forced in sync
  // Synchroniser resets to the idle level, so all-sent does not dip
  // for two cycles after reset while the transmitter is empty
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      tx_idle_s1_r <= 1'b1;
      tx_idle_s2_r <= 1'b1;
      all_sent_r   <= 1'b1;
    end else begin
      tx_idle_s1_r <= tx_idle;
      tx_idle_s2_r <= tx_idle_s1_r;
      all_sent_r   <= (mode != srsv_pkg::SRSV_MODE_ASYNC) || tx_idle_s2_r;
    end
  end

  // Status byte presents the head character's own flags
  always_comb begin
    status_byte = 8'h00;
    status_byte[srsv_pkg::BIT_ALL_SENT]    = all_sent_r;
    status_byte[srsv_pkg::BIT_RES_LO +: 3] = not_empty ? head.residue : srsv_pkg::RES_NONE_8;
    status_byte[srsv_pkg::BIT_PAR]         = par_lat_r || (not_empty && head.par_err);
    status_byte[srsv_pkg::BIT_OVR]         = ovr_lat_r || (not_empty && head.ovr);
    status_byte[srsv_pkg::BIT_CRCF]        = not_empty ? head.crcf : crcf_r;
    status_byte[srsv_pkg::BIT_EOF]         = not_empty ? head.eof : eof_r;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Vector readback

  logic special_pending;
  assign special_pending = status_byte[srsv_pkg::BIT_OVR] || status_byte[srsv_pkg::BIT_PAR]
                           || status_byte[srsv_pkg::BIT_CRCF] || status_byte[srsv_pkg::BIT_EOF];

  always_comb begin
    vec_byte = vecwr_r;
    if (sav) begin
      if (special_pending) begin
        vec_byte[3:1] = srsv_pkg::VEC_SPECIAL;
      end else if (not_empty) begin
        vec_byte[3:1] = srsv_pkg::VEC_RXAVAIL;
      end else begin
        vec_byte[3:1] = srsv_pkg::VEC_NONE;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Interrupt events: 0 overrun, 1 parity, 2 crc/framing, 3 end of frame

  // All-sent changes never enter here
  assign evt = {new_char.eof, new_char.crcf, new_char.par_err, 1'b0}
               & {4{rx_in.valid}} | {3'h0, overrun};
  assign hit = |(irq_stat_r & irq_en_r);

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_stat_r <= srsv_pkg::RST_IRQ;
    end else begin
      irq_stat_r <= (irq_stat_r & ~((wr_acc && paddr == srsv_pkg::OFF_IRQ_CLR)
                    ? pwdata[3:0] : 4'h0)) | evt;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= hit;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB register write and read

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      vecwr_r  <= srsv_pkg::RST_VECWR;
      ctrl_r   <= srsv_pkg::RST_CTRL;
      irq_en_r <= srsv_pkg::RST_IRQ;
    end else if (wr_acc) begin
      case (paddr)
        srsv_pkg::OFF_VECWR:  vecwr_r  <= pwdata[7:0];
        srsv_pkg::OFF_CTRL:   ctrl_r   <= pwdata[7:0];
        srsv_pkg::OFF_IRQ_EN: irq_en_r <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      prdata_r  <= 32'h0000_0000;
      pready_r  <= 1'b0;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= psel && !penable;
      pslverr_r <= psel && !penable && !addr_ok(paddr, is_chb);
      prdata_r  <= 32'h0000_0000;
      if (psel && !penable && !pwrite) begin
        case (paddr)
          srsv_pkg::OFF_STATUS:   prdata_r <= {24'h0, status_byte};
          srsv_pkg::OFF_VECRD:    prdata_r <= is_chb ? {24'h0, vec_byte} : 32'h0;
          srsv_pkg::OFF_VECWR:    prdata_r <= {24'h0, vecwr_r};
          srsv_pkg::OFF_CTRL:     prdata_r <= {24'h0, ctrl_r};
          srsv_pkg::OFF_DATA:     prdata_r <= {24'h0, head.data};
          srsv_pkg::OFF_IRQ_STAT: prdata_r <= {28'h0, irq_stat_r};
          srsv_pkg::OFF_IRQ_EN:   prdata_r <= {28'h0, irq_en_r};
          default:                prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign prdata        = prdata_r;
  assign pready        = pready_r;
  assign pslverr       = pslverr_r;
  assign irq           = irq_r;
  assign frame_stretch = stretch_r;

endmodule // srsv_top
